// file: common/accum_alu_map.svh
// Constants for the accumulator ALU datapath: opcodes, timing, map.
// Assumes inclusion by the package, the monitor and the bench before any use.
//
// Overview of operation
// RULE1 - Add source, accumulator and carry; flags NZCV
// RULE2 - Accumulator ops target register or indexed memory
// RULE3 - Accumulator comes from the active bank
// RULE4 - Add 8-bit immediate into limited register
// RULE5 - Immediate forms address only registers 0-15
// RULE6 - Immediate is eight bits, signed or unsigned
// RULE7 - AND immediate opcode 0100, flags N Z only
// RULE8 - AND source with accumulator; flags N Z
// RULE9 - Add source to accumulator; flags NZCV
// RULE10 - Bit test sets N Z, no writeback, 2 T-states
// RULE11 - Compare subtracts immediate, sets NZCV, no write
// RULE12 - Call pushes PC, flags, enable, bank selections
// RULE13 - Call adds sign-extended displacement to PC
// RULE14 - Displacement adds to next instruction address
// RULE15 - Complement any of 32 registers; flags N Z
// RULE16 - Post-increment writes memory then bumps pointer
// RULE17 - Receive entry 11 bits; status top, pop on read
// RULE18 - Interrupt mask bits are register low two bits
// RULE19 - Transmit empty flag is command flag bit 7
// RULE20 - Software writes complemented fill-bit count
// RULE21 - Bank A swaps R0-R3, bank B R4-R11
// RULE22 - N is result bit 7, Z when all zero
// RULE23 - Unaffected flags keep their previous values
`ifndef ACCUM_ALU_MAP_SVH
`define ACCUM_ALU_MAP_SVH

// Bus register byte offsets
`define OFS_CTRL 12'h000
`define OFS_INSTR 12'h004
`define OFS_STATUS 12'h008
`define OFS_PC 12'h00c
`define OFS_REGSEL 12'h010
`define OFS_REGDATA 12'h014
`define OFS_INDEX 12'h018
`define OFS_STACK 12'h01c
`define OFS_RXPUSH 12'h020
`define OFS_MEMDATA 12'h024

// Control field positions
`define CTRL_BA 0
`define CTRL_BB 1
`define CTRL_GIE 2
`define CTRL_TXDONE 3

// Opcode top fields
`define OP4_ADD_IMM 4'h0
`define OP4_AND_IMM 4'h4
`define OP4_CMP_IMM 4'h6
`define OP5_BIT_IMM 5'h0f
`define OP8_CALL 8'hcb
`define OP3_ACC 3'h5
`define OP11_CPL 11'h578

// Accumulator sub-ops in bits 7:5
`define ACC_ADD 3'h0
`define ACC_ADC 3'h1
`define ACC_AND 3'h2

// Register numbers of special registers
`define REG_ACC 5'h00
`define REG_NCF 5'h01
`define REG_ICR 5'h02
`define REG_FBR 5'h03
`define REG_TSR 5'h04
`define REG_RTR 5'h05

// Timing in T-states
`define T_SHORT 2'h2
`define T_LONG 2'h3

`define MASK_RESET 8'h03
`endif

// file: common/accum_alu_pkg.sv
// Types for the accumulator ALU datapath.
// Assumes the map header is on the include path.
`include "accum_alu_map.svh"
package accum_alu_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_exec = 3'b010,
        st_done = 3'b100
    } exec_state_type;
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } flags_type;
endpackage

// file: hw/accum_alu.sv
// Accumulator ALU datapath with AHB-Lite register access.
// Assumes a single AHB-Lite master issuing word-sized single transfers.
`timescale 1ns/10ps
module accum_alu
    import accum_alu_pkg::*;
#(
    parameter int STACK_DEPTH = 8,
    parameter int MEM_WORDS = 64
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Status
    output logic busy,
    output logic irq_tx_mask,
    output logic irq_rx_mask
);

    localparam int AW = $clog2(MEM_WORDS);
    localparam int SW = $clog2(STACK_DEPTH);

    // Architectural state
    logic [7:0] gpr [0:31];
    logic [7:0] alt_a [0:3];
    logic [7:0] alt_b [4:11];
    logic [7:0] dmem [0:MEM_WORDS-1];
    logic [28:0] stack [0:STACK_DEPTH-1];
    logic [SW:0] sp;
    logic [15:0] pc;
    logic [15:0] index_pointer_z;
    flags_type flags;
    logic global_irq_enable;
    logic bank_a;
    logic bank_b;
    logic tx_fifo_empty;
    logic [10:0] rx_fifo [0:3];
    logic [2:0] rx_count;
    logic [15:0] instr;
    logic [1:0] tcount;
    exec_state_type state;
    logic [4:0] reg_sel;
    logic [7:0] irq_mask_reg;

    // Bus address phase capture
    logic ap_valid;
    logic ap_write;
    logic [11:0] ap_addr;
    logic bus_read;
    logic bus_write;
    assign bus_write = ap_valid && ap_write;
    assign bus_read = hsel && hready && htrans[1] && !hwrite;

    // Reads a register as seen through the active banks
    function automatic logic [7:0] rd_reg(input logic [4:0] r);
        logic [7:0] v;
        v = gpr[r];
        if (r < 5'd4 && bank_a) begin
            v = alt_a[r[1:0]];                     // [RULE21]
        end
        if (r >= 5'd4 && r < 5'd12 && bank_b) begin
            v = alt_b[r];                          // [RULE21]
        end
        if (r == `REG_TSR) begin
            v = {5'h00, rx_fifo[0][10:8]};         // [RULE17]
        end
        if (r == `REG_RTR) begin
            v = rx_fifo[0][7:0];                   // [RULE17]
        end
        if (r == `REG_NCF) begin
            v = {tx_fifo_empty, gpr[r][6:0]};      // [RULE19]
        end
        if (r == `REG_ICR) begin
            v = irq_mask_reg;                               // [RULE18]
        end
        return v;
    endfunction

    // Add with carry giving the flags of the sum; the result is formed by the caller
    function automatic flags_type add_flags(input logic [7:0] a,
            input logic [7:0] b, input logic ci, input flags_type f);
        logic [8:0] s;
        flags_type o;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        o.n = s[7];                                // [RULE22]
        o.z = (s[7:0] == 8'h00);                   // [RULE22]
        o.c = s[8];
        o.v = (a[7] == b[7]) && (s[7] != a[7]);
        o = o;
        return o;
    endfunction

    // Logical result flags, carry and overflow kept
    function automatic flags_type log_flags(input logic [7:0] r,
            input flags_type f);
        flags_type o;
        o = f;                                     // [RULE23]
        o.n = r[7];                                // [RULE22]
        o.z = (r == 8'h00);                        // [RULE22]
        return o;
    endfunction

    // Decode of the held instruction
    logic [7:0] imm;
    logic [3:0] rlim;
    logic [4:0] src;
    logic to_mem;
    logic [7:0] accum;
    logic [7:0] src_val;
    logic [7:0] lim_val;
    assign imm = instr[11:4];                      // [RULE6]
    assign rlim = instr[3:0];                      // [RULE5]
    assign src = instr[4:0];
    assign to_mem = instr[12];
    assign accum = rd_reg(`REG_ACC);               // [RULE3]
    assign src_val = rd_reg(src);
    assign lim_val = rd_reg({1'b0, rlim});

    // Result and write decisions
    logic [7:0] result;
    flags_type next_flags;
    logic wr_reg;
    logic wr_mem;
    logic do_call;
    logic [4:0] wr_idx;
    always_comb begin
        result = 8'h00;
        next_flags = flags;                        // [RULE23]
        wr_reg = 1'b0;
        wr_mem = 1'b0;
        do_call = 1'b0;
        wr_idx = {1'b0, rlim};
        if (instr[15:12] == `OP4_ADD_IMM) begin
            result = lim_val + imm;                // [RULE4]
            next_flags = add_flags(lim_val, imm, 1'b0, flags);
            wr_reg = 1'b1;
        end else if (instr[15:12] == `OP4_AND_IMM) begin
            result = lim_val & imm;                // [RULE7]
            next_flags = log_flags(result, flags);
            wr_reg = 1'b1;
        end else if (instr[15:12] == `OP4_CMP_IMM) begin
            result = lim_val - imm;                // [RULE11]
            next_flags = add_flags(lim_val, ~imm, 1'b1, flags);
        end else if (instr[15:11] == `OP5_BIT_IMM) begin
            result = lim_val & imm;                // [RULE10]
            next_flags = log_flags(result, flags);
        end else if (instr[15:8] == `OP8_CALL) begin
            do_call = 1'b1;                        // [RULE12]
        end else if (instr[15:5] == `OP11_CPL) begin
            wr_idx = src;
            result = ~src_val;                     // [RULE15]
            next_flags = log_flags(result, flags);
            wr_reg = 1'b1;
        end else if (instr[15:13] == `OP3_ACC) begin
            wr_idx = {1'b0, instr[11:8]};
            unique case (instr[7:5])
                `ACC_ADD: begin
                    result = src_val + accum;      // [RULE9]
                    next_flags = add_flags(src_val, accum, 1'b0, flags);
                end
                `ACC_ADC: begin
                    result = src_val + accum + {7'h00, flags.c};
                    next_flags = add_flags(src_val, accum, flags.c,
                        flags);                    // [RULE1]
                end
                `ACC_AND: begin
                    result = src_val & accum;      // [RULE8]
                    next_flags = log_flags(result, flags);
                end
                default: begin
                    result = 8'h00;
                end
            endcase
            wr_mem = to_mem;                       // [RULE2]
            wr_reg = !to_mem;                      // [RULE2]
        end
    end

    // Execution sequencer counting T-states
    logic fire;
    assign fire = (state == st_exec) && (tcount == 2'h1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= st_idle;
            tcount <= 2'h0;
        end else begin
            unique case (state)
                st_idle: begin
                    if (bus_write && ap_addr == `OFS_INSTR) begin
                        state <= st_exec;
                        tcount <= (hwdata[15:8] == `OP8_CALL ||
                            (hwdata[15:13] == `OP3_ACC &&
                            hwdata[12])) ? `T_LONG : `T_SHORT; // [RULE10]
                    end
                end
                st_exec: begin
                    tcount <= tcount - 2'h1;
                    if (tcount == 2'h1) begin
                        state <= st_done;
                    end
                end
                st_done: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // Instruction capture and program counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr <= 16'h0000;
            pc <= 16'h0000;
        end else if (state == st_idle && bus_write && ap_addr == `OFS_INSTR)
        begin
            instr <= hwdata[15:0];
            pc <= pc + 16'h0001;                   // [RULE14]
        end else if (bus_write && ap_addr == `OFS_PC) begin
            pc <= hwdata[15:0];
        end else if (fire && do_call) begin
            pc <= pc + {{8{instr[7]}}, instr[7:0]}; // [RULE13]
        end
    end

    // Flags, banks, interrupt enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= '0;
            bank_a <= 1'b0;
            bank_b <= 1'b0;
            global_irq_enable <= 1'b0;
            tx_fifo_empty <= 1'b0;
        end else begin
            if (fire) begin
                flags <= next_flags;
            end
            if (bus_write && ap_addr == `OFS_CTRL) begin
                bank_a <= hwdata[`CTRL_BA];        // [RULE21]
                bank_b <= hwdata[`CTRL_BB];
                global_irq_enable <= hwdata[`CTRL_GIE];
                tx_fifo_empty <= hwdata[`CTRL_TXDONE]; // [RULE19]
            end
        end
    end

    // Call stack
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp <= '0;
        end else if (fire && do_call && sp < STACK_DEPTH[SW:0]) begin
            stack[sp[SW-1:0]] <= {6'h00, pc, global_irq_enable, flags,
                bank_a, bank_b};                   // [RULE12]
            sp <= sp + 1'b1;
        end
    end

    // Register file and data memory writes
    always_ff @(posedge hclk) begin
        if (fire && wr_reg) begin
            if (wr_idx < 5'd4 && bank_a) begin
                alt_a[wr_idx[1:0]] <= result;      // [RULE3]
            end else if (wr_idx >= 5'd4 && wr_idx < 5'd12 && bank_b) begin
                alt_b[wr_idx] <= result;
            end else begin
                gpr[wr_idx] <= result;
            end
        end else if (bus_write && ap_addr == `OFS_REGDATA) begin
            gpr[reg_sel] <= hwdata[7:0];
        end
        if (fire && wr_mem) begin
            dmem[index_pointer_z[AW-1:0]] <= result; // [RULE16]
        end
    end

    // Index pointer with post increment
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            index_pointer_z <= 16'h0000;
            reg_sel <= 5'h00;
        end else if (fire && wr_mem) begin
            index_pointer_z <= index_pointer_z + 16'h0001; // [RULE16]
        end else if (bus_write && ap_addr == `OFS_INDEX) begin
            index_pointer_z <= hwdata[15:0];
        end else if (bus_write && ap_addr == `OFS_REGSEL) begin
            reg_sel <= hwdata[4:0];
        end
    end

    // Receive FIFO, pushed by bus, popped by data read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_count <= 3'h0;
            for (int i = 0; i < 4; i++) begin
                rx_fifo[i] <= 11'h000;
            end
        end else if (bus_read && haddr[11:0] == `OFS_REGDATA &&
                reg_sel == `REG_RTR && rx_count != 3'h0) begin
            for (int i = 0; i < 3; i++) begin
                rx_fifo[i] <= rx_fifo[i+1];        // [RULE17]
            end
            rx_fifo[3] <= 11'h000;
            rx_count <= rx_count - 3'h1;
        end else if (bus_write && ap_addr == `OFS_RXPUSH &&
                rx_count != 3'h4) begin
            rx_fifo[rx_count[1:0]] <= hwdata[10:0];
            rx_count <= rx_count + 3'h1;
        end
    end

    // Mask register kept apart so both masks are set from reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_reg <= `MASK_RESET;                    // [RULE18]
        end else if (fire && wr_reg && wr_idx == `REG_ICR) begin
            irq_mask_reg <= result;
        end else if (bus_write && ap_addr == `OFS_REGDATA &&
                reg_sel == `REG_ICR) begin
            irq_mask_reg <= hwdata[7:0];
        end
    end

    // Interrupt mask outputs follow register R2 low bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_tx_mask <= 1'b1;
            irq_rx_mask <= 1'b1;
            busy <= 1'b0;
        end else begin
            irq_tx_mask <= irq_mask_reg[0];                 // [RULE18]
            irq_rx_mask <= irq_mask_reg[1];                 // [RULE18]
            busy <= (state != st_idle) ||
                (bus_write && ap_addr == `OFS_INSTR);
        end
    end

    // AHB address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 12'h000;
            hrdata <= 32'h0000_0000;
        end else begin
            ap_valid <= hsel && hready && htrans[1];
            ap_write <= hwrite;
            ap_addr <= haddr[11:0];
            if (bus_read) begin
                unique case (haddr[11:0])
                    `OFS_CTRL: hrdata <= {28'h0, tx_fifo_empty,
                        global_irq_enable, bank_b, bank_a};
                    `OFS_INSTR: hrdata <= {16'h0, instr};
                    `OFS_STATUS: hrdata <= {24'h0, sp[3:0] & 4'hf,
                        flags};
                    `OFS_PC: hrdata <= {16'h0, pc};
                    `OFS_REGSEL: hrdata <= {27'h0, reg_sel};
                    `OFS_REGDATA: hrdata <= {24'h0, rd_reg(reg_sel)};
                    `OFS_INDEX: hrdata <= {16'h0, index_pointer_z};
                    `OFS_STACK: hrdata <= {3'h0,
                        stack[sp[SW-1:0] - 1'b1]};
                    `OFS_MEMDATA: hrdata <= {24'h0,
                        dmem[index_pointer_z[AW-1:0] - 1'b1]};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Zero-wait OKAY slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule // accum_alu

// file: verif/accum_alu_monitor.sv
// Port checker for the accumulator ALU block.
// Assumes the map header gives the register offsets.
`timescale 1ns/10ps
`include "accum_alu_map.svh"
module accum_alu_monitor #(
    parameter int STACK_DEPTH = 8,
    parameter int MEM_WORDS = 64
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Status
    input wire logic busy,
    input wire logic irq_tx_mask,
    input wire logic irq_rx_mask
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic rd_ap;
    logic wr_dph;
    logic [11:0] wr_ofs;
    logic go;
    logic [3:0] busy_len;
    // Decode reads and instruction starts
    assign rd_ap = hsel && hready && htrans[1] && !hwrite;
    assign go = wr_dph && (wr_ofs == `OFS_INSTR);
    // Write data phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dph <= 1'b0;
            wr_ofs <= 12'h000;
        end else if (hready) begin
            wr_dph <= hsel && htrans[1] && hwrite;
            wr_ofs <= haddr[11:0];
        end
    end
    // Length of a busy stretch, so a hang cannot hide
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_len <= 4'h0;
        end else begin
            busy_len <= busy ? busy_len + 4'h1 : 4'h0;
        end
    end
    AST_MASK_RESET: assert property ($rose(hresetn) |->
        irq_tx_mask && irq_rx_mask) else $error("masks low after reset");
    AST_MASK_CLEAR: assert property (
        go && !busy && hwdata[15:0] == 16'h4fc2
        |-> ##[1:8] (!irq_tx_mask && !irq_rx_mask))
        else $error("masks not cleared by and");
    AST_BUSY_CAUSE: assert property (
        $rose(busy) |-> $past(go) || $past(go, 2))
        else $error("busy without instruction");
    AST_BUSY_START: assert property (go && !busy |-> ##[1:2] busy)
        else $error("instruction did not start");
    AST_BUSY_LEN: assert property (busy_len < 4'h6)
        else $error("instruction too long");
    AST_PC_WIDTH: assert property (
        rd_ap && haddr[11:0] == `OFS_PC |=> hrdata[31:16] == 16'h0000)
        else $error("pc wider than 16 bits");
    AST_REG_WIDTH: assert property (
        rd_ap && haddr[11:0] == `OFS_REGDATA |=> hrdata[31:8] == 24'h0)
        else $error("register wider than 8 bits");
    AST_FLAG_WIDTH: assert property (
        rd_ap && haddr[11:0] == `OFS_STATUS |=> hrdata[31:8] == 24'h0)
        else $error("status wider than 8 bits");
endmodule // accum_alu_monitor

bind accum_alu accum_alu_monitor #(.STACK_DEPTH(STACK_DEPTH),
    .MEM_WORDS(MEM_WORDS)) accum_alu_monitor_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .busy(busy), .irq_tx_mask(irq_tx_mask),
    .irq_rx_mask(irq_rx_mask));

// file: verif/ahb_host.sv
// Software-side bus master making single word transfers.
// Assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/10ps
module ahb_host (
    // Clock and answer
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Idle bus from time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // One transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [11:0] ofs,
            input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {20'h0, ofs};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
endmodule // ahb_host

// file: verif/tb_top.sv
// Self-checking bench for the accumulator ALU over its register bus.
// Assumes the host model and the bound port checker.
`timescale 1ns/10ps
`include "accum_alu_map.svh"
module tb_top;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, busy;
    logic irq_tx_mask, irq_rx_mask;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int failures, samples_checked, busy_cycles, bit_cycles;
    assign hready = hreadyout;
    // Block and its software side
    accum_alu #(.STACK_DEPTH(8), .MEM_WORDS(64)) accum_alu_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .busy(busy), .irq_tx_mask(irq_tx_mask),
        .irq_rx_mask(irq_rx_mask));
    ahb_host ahb_host_i (.hclk(hclk), .hready(hready), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));
    // Clock
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Register access helpers
    task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
        ahb_host_i.xfer(1'b1, ofs, d, rd);
    endtask
    task automatic rchk(input logic [11:0] ofs, input logic [31:0] m,
            input logic [31:0] e);
        ahb_host_i.xfer(1'b0, ofs, 32'h0, rd);
        check(rd & m, e);
    endtask
    task automatic setr(input logic [4:0] r, input logic [7:0] v);
        wr(`OFS_REGSEL, {27'h0, r});
        wr(`OFS_REGDATA, {24'h0, v});
    endtask
    task automatic getr(input logic [4:0] r, input logic [7:0] e);
        wr(`OFS_REGSEL, {27'h0, r});
        rchk(`OFS_REGDATA, 32'hff, {24'h0, e});
    endtask
    task automatic fl(input logic [3:0] m, input logic [3:0] e);
        rchk(`OFS_STATUS, {28'h0, m}, {28'h0, e});
    endtask
    // Start an instruction and count its busy cycles
    task automatic exec(input logic [15:0] op);
        wr(`OFS_INSTR, {16'h0, op});
        busy_cycles = 0;
        for (int i = 0; i < 16; i++) begin
            @(posedge hclk);
            if (busy === 1'b1) busy_cycles++;
            else if (busy_cycles > 0) break;
        end
    endtask
    function automatic logic [15:0] acc(input logic m, input logic [3:0] d,
            input logic [2:0] s, input logic [4:0] r);
        return {3'b101, m, d, s, r};
    endfunction
    // Hang guard
    initial begin
        repeat (6000) @(posedge hclk);
        failures++;
        final_report();
    end
    // Main sequence
    initial begin
        failures = 0;
        samples_checked = 0;
        hresetn = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check({30'h0, irq_tx_mask, irq_rx_mask}, 32'h3);
        rchk(`OFS_STATUS, 32'hf0, 32'h0);
        // Immediate add, unsigned then signed
        setr(5'd6, 8'hf0);
        exec({`OP4_ADD_IMM, 8'h20, 4'h6});
        getr(5'd6, 8'h10);
        fl(4'hf, 4'h2);
        setr(5'd9, 8'h80);
        exec({`OP4_ADD_IMM, 8'hff, 4'h9});
        getr(5'd9, 8'h7f);
        fl(4'hf, 4'h3);
        // Accumulator forms into registers
        setr(5'd0, 8'h05);
        exec(acc(1'b0, 4'h7, `ACC_ADC, 5'd6));
        getr(5'd7, 8'h16);
        fl(4'hf, 4'h0);
        setr(5'd8, 8'h7b);
        exec(acc(1'b0, 4'ha, `ACC_ADD, 5'd8));
        getr(5'd10, 8'h80);
        fl(4'hf, 4'h9);
        exec(acc(1'b0, 4'hb, `ACC_AND, 5'd8));
        getr(5'd11, 8'h01);
        fl(4'hf, 4'h1);
        // Unmask both interrupts, overflow kept
        exec({`OP4_AND_IMM, 8'hfc, 4'h2});
        check({30'h0, irq_tx_mask, irq_rx_mask}, 32'h0);
        fl(4'hf, 4'h5);
        // Bit test of transmit empty, set then clear
        wr(`OFS_CTRL, 32'h8);
        exec({4'h7, 8'h80, 4'h1});
        bit_cycles = busy_cycles;
        fl(4'hf, 4'h9);
        wr(`OFS_CTRL, 32'h0);
        exec({4'h7, 8'h80, 4'h1});
        fl(4'hf, 4'h5);
        exec({4'h7, 8'h90, 4'h6});
        fl(4'hf, 4'h1);
        getr(5'd6, 8'h10);
        // Calls back and forward, state pushed
        wr(`OFS_CTRL, 32'h7);
        wr(`OFS_PC, 32'h0100);
        exec({`OP8_CALL, 8'hfe});
        check(busy_cycles, bit_cycles + 1);
        rchk(`OFS_PC, 32'hffff, 32'h00ff);
        rchk(`OFS_STACK, 32'h7fffff,
            {9'h0, 16'h0101, 1'b1, 4'h1, 2'h3});
        exec({`OP8_CALL, 8'h7f});
        rchk(`OFS_PC, 32'hffff, 32'h017f);
        rchk(`OFS_STATUS, 32'hf0, 32'h20);
        wr(`OFS_CTRL, 32'h0);
        // Compare never writes back
        exec({`OP4_CMP_IMM, 8'h10, 4'h6});
        fl(4'hc, 4'h4);
        exec({`OP4_CMP_IMM, 8'h20, 4'h6});
        fl(4'hc, 4'h8);
        getr(5'd6, 8'h10);
        // Complement, high register and fill count
        setr(5'd20, 8'h0f);
        exec({`OP11_CPL, 5'd20});
        getr(5'd20, 8'hf0);
        fl(4'hc, 4'h8);
        setr(5'd3, 8'h05);
        exec({`OP11_CPL, 5'd3});
        getr(5'd3, 8'hfa);
        // Alternate banks, main registers retained
        setr(5'd12, 8'h30);
        wr(`OFS_CTRL, 32'h3);
        exec({`OP4_AND_IMM, 8'h00, 4'h0});
        exec({`OP4_ADD_IMM, 8'h09, 4'h0});
        exec({`OP4_AND_IMM, 8'h00, 4'h8});
        exec(acc(1'b0, 4'hd, `ACC_ADD, 5'd12));
        getr(5'd13, 8'h39);
        wr(`OFS_CTRL, 32'h0);
        getr(5'd0, 8'h05);
        getr(5'd8, 8'h7b);
        exec(acc(1'b0, 4'he, `ACC_ADD, 5'd12));
        getr(5'd14, 8'h35);
        // Indexed post-increment destination
        wr(`OFS_INDEX, 32'h0a);
        exec(acc(1'b1, 4'h0, `ACC_ADD, 5'd12));
        rchk(`OFS_INDEX, 32'hffff, 32'h0b);
        rchk(`OFS_MEMDATA, 32'hff, 32'h35);
        exec(acc(1'b1, 4'h0, `ACC_AND, 5'd12));
        rchk(`OFS_INDEX, 32'hffff, 32'h0c);
        rchk(`OFS_MEMDATA, 32'hff, 32'h00);
        // Receive entries split and popped in order
        wr(`OFS_RXPUSH, 32'h5a3);
        wr(`OFS_RXPUSH, 32'h27e);
        getr(5'd4, 8'h05);
        getr(5'd5, 8'ha3);
        getr(5'd4, 8'h02);
        getr(5'd5, 8'h7e);
        // Unmapped place drops writes, reads zero
        wr(12'h040, 32'hffffffff);
        rchk(12'h040, 32'hffffffff, 32'h0);
        final_report();
    end
endmodule // tb_top
